/* File: qct_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module qct_edge_sync
    import qct_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       pin_in,
    input  wire logic [1:0] edge_sel,
    output logic            strobe
);
    // ----------------------------------------------------------------
    // three-stage synchroniser and settled level
    // ----------------------------------------------------------------
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    wire settled = (s2_r == s3_r);
    wire changed = settled && (s3_r != level_r);
    wire rose    = changed && s3_r;
    wire fell    = changed && !s3_r;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_r <= 1'b0;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (changed)
                level_r <= s3_r;
        end
    end

    // ----------------------------------------------------------------
    // one-cycle strobe per qualifying edge
    // ----------------------------------------------------------------
    assign strobe = ((edge_sel == QCT_EDGE_RISE) && rose) ||
                    ((edge_sel == QCT_EDGE_FALL) && fell) ||
                    ((edge_sel == QCT_EDGE_BOTH) && changed);
endmodule
`default_nettype wire

/* File: qct_pkg.sv */
`default_nettype none
package qct_pkg;
    // ----------------------------------------------------------------
    // counter and channel geometry
    // ----------------------------------------------------------------
    localparam int          QCT_CNT_W     = 16;
    localparam int          QCT_NCH       = 4;
    localparam logic [15:0] QCT_CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] QCT_CNT_ZERO  = 16'h0000;
    localparam logic [15:0] QCT_CCR_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // operating mode codes
    // ----------------------------------------------------------------
    localparam logic [2:0]  QCT_MODE_PWM  = 3'h4;
    localparam logic [2:0]  QCT_MODE_FREE = 3'h5;

    // ----------------------------------------------------------------
    // option byte layout
    // ----------------------------------------------------------------
    localparam int          QCT_WRAP_FLAG_BIT = 0;

    // ----------------------------------------------------------------
    // capture edge select codes
    // ----------------------------------------------------------------
    localparam logic [1:0]  QCT_EDGE_NONE = 2'h0;
    localparam logic [1:0]  QCT_EDGE_RISE = 2'h1;
    localparam logic [1:0]  QCT_EDGE_FALL = 2'h2;
    localparam logic [1:0]  QCT_EDGE_BOTH = 2'h3;
endpackage
`default_nettype wire

/* File: qct_timer.sv */
// Functional notes
// - in pwm mode a duty channel with compare value zero stays inactive all period.
// - a duty value of period plus one gives a full-active output, impossible at period FFFF.
// - in pwm mode a duty channel's match request rises in the cycle the count equals it.
// - mode code 101 selects the free-running timer.
// - in free-running mode the counter advances each clock once the run bit is one.
// - in free-running mode each channel is compare or capture as its function select bit says.
// - in free-running mode all four outputs invert when the run bit is set and counting starts.
// - in free-running mode a compare match raises the channel request and inverts its output.
// - in free-running mode the clock after the count holds FFFF raises the wrap request and wraps to zero.
// - each wrap sets the sticky wrap flag until software clears it.
// - a compare register write is used in the very next comparison.
// - a capture edge latches the count into the channel register and raises its request.
// - the wrap flag is bit zero of the option byte and a byte write with it zero clears it.
`timescale 1ns/1ps
`default_nettype none
module qct_timer
    import qct_pkg::*;
#(
    parameter int NCH = QCT_NCH
)
(
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire logic [2:0]                  operating_mode_field,
    input  wire logic                        count_run_bit,
    input  wire logic [NCH-1:0]              channel_function_sel,
    input  wire logic [2*NCH-1:0]            capture_edge_sel,
    input  wire logic                        ccr_wr_en,
    input  wire logic [$clog2(NCH)-1:0]      ccr_wr_idx,
    input  wire logic [15:0]                 ccr_wr_data,
    input  wire logic                        opt_byte_wr,
    input  wire logic [7:0]                  opt_byte_data,
    input  wire logic                        bit_clear_instruction,
    input  wire logic [NCH-1:0]              capture_in_pin,
    output logic      [NCH-1:0][15:0]        capture_compare_reg,
    output logic      [15:0]                 count_value,
    output logic                             wrap_flag,
    output logic                             wrap_irq,
    output logic      [NCH-1:0]              channel_event_irq,
    output logic      [NCH-1:0]              timer_out_pin
);
    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (NCH != QCT_NCH)
    begin : g_bad_nch
        $error("qct_timer serves exactly four channels");
    end

    localparam int IDX_W = $clog2(NCH);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [15:0]            cnt_r;
    logic [15:0]            cnt_nxt;
    logic                   run_q_r;
    logic                   wrap_flag_r;
    logic                   wrap_flag_nxt;
    logic                   wrap_irq_r;
    logic                   period_irq_r;
    logic [NCH-1:0]         cap_irq_r;
    logic [NCH-1:0]         out_r;
    logic [NCH-1:0]         out_nxt;
    logic [NCH-1:0][15:0]   ccr_r;

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    wire free_mode = (operating_mode_field == QCT_MODE_FREE);
    wire pwm_mode  = (operating_mode_field == QCT_MODE_PWM);
    wire running   = count_run_bit && (free_mode || pwm_mode);
    wire run_start = running && !run_q_r;
    wire at_max    = (cnt_r == QCT_CNT_MAX);
    wire period_hit = pwm_mode && running && (cnt_r == ccr_r[0]);
    wire wrap_now  = free_mode && running && at_max;

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    assign cnt_nxt = !running   ? QCT_CNT_ZERO :
                     period_hit ? QCT_CNT_ZERO :
                     16'(cnt_r + 16'h0001);

    // ----------------------------------------------------------------
    // per-channel capture, compare and output logic
    // ----------------------------------------------------------------
    logic [NCH-1:0] cap_strobe;
    logic [NCH-1:0] is_capture;
    logic [NCH-1:0] cmp_hit;
    logic [NCH-1:0] duty_active;
    logic [NCH-1:0] cap_take;
    logic [NCH-1:0] sw_write;

    genvar m;
    generate
        for (m = 0; m < NCH; m++)
        begin : g_ch
            qct_edge_sync u_sync (
                .clk      (clk),
                .reset    (reset),
                .pin_in   (capture_in_pin[m]),
                .edge_sel (capture_edge_sel[2*m +: 2]),
                .strobe   (cap_strobe[m])
            );

            assign is_capture[m] = free_mode && channel_function_sel[m];
            // live register compared directly, so writes apply at once
            assign cmp_hit[m] = running && !is_capture[m] &&
                                (cnt_r == ccr_r[m]) &&
                                (free_mode || (pwm_mode && (m != 0)));
            // active while count below duty: zero never, period+1 always
            assign duty_active[m] = ({1'b0, cnt_r} < {1'b0, ccr_r[m]});
            assign cap_take[m] = running && is_capture[m] && cap_strobe[m];
            assign sw_write[m] = ccr_wr_en && (ccr_wr_idx == IDX_W'(m));

            always_comb
            begin
                out_nxt[m] = out_r[m];
                if (free_mode)
                begin
                    if (run_start ^ (cmp_hit[m] && !run_start))
                        out_nxt[m] = !out_r[m];
                    else if (run_start && cmp_hit[m])
                        out_nxt[m] = !out_r[m];
                end
                else if (pwm_mode)
                begin
                    if (!running)
                        out_nxt[m] = 1'b0;
                    else if (m == 0)
                        out_nxt[m] = period_hit ? !out_r[m] : out_r[m];
                    else
                        out_nxt[m] = duty_active[m];
                end
            end

            always_ff @(posedge clk)
            begin
                if (reset)
                begin
                    ccr_r[m]     <= QCT_CCR_RESET;
                    cap_irq_r[m] <= 1'b0;
                    out_r[m]     <= 1'b0;
                end
                else
                begin
                    if (cap_take[m])
                        ccr_r[m] <= cnt_r;
                    else if (sw_write[m])
                        ccr_r[m] <= ccr_wr_data;
                    cap_irq_r[m] <= cap_take[m];
                    out_r[m]     <= out_nxt[m];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // wrap flag: set wins over clear
    // ----------------------------------------------------------------
    wire byte_clear = opt_byte_wr && !opt_byte_data[QCT_WRAP_FLAG_BIT];
    wire flag_clear = bit_clear_instruction || byte_clear;

    assign wrap_flag_nxt = wrap_now   ? 1'b1 :
                           flag_clear ? 1'b0 :
                           wrap_flag_r;

    // ----------------------------------------------------------------
    // shared registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cnt_r        <= QCT_CNT_ZERO;
            run_q_r      <= 1'b0;
            wrap_flag_r  <= 1'b0;
            wrap_irq_r   <= 1'b0;
            period_irq_r <= 1'b0;
        end
        else
        begin
            cnt_r        <= cnt_nxt;
            run_q_r      <= running;
            wrap_flag_r  <= wrap_flag_nxt;
            wrap_irq_r   <= wrap_now;
            period_irq_r <= period_hit;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    wire [NCH-1:0] ch0_period = {{(NCH-1){1'b0}}, period_irq_r};

    assign channel_event_irq   = cmp_hit | cap_irq_r | ch0_period;
    assign capture_compare_reg = ccr_r;
    assign count_value         = cnt_r;
    assign wrap_flag           = wrap_flag_r;
    assign wrap_irq            = wrap_irq_r;
    assign timer_out_pin       = out_r;
endmodule
`default_nettype wire

/* File: qct_timer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module qct_timer_properties
    import qct_pkg::*;
#(
    parameter int NCH = QCT_NCH
)
(
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic [2:0]           operating_mode_field,
    input wire logic                 count_run_bit,
    input wire logic [NCH-1:0]       channel_function_sel,
    input wire logic                 bit_clear_instruction,
    input wire logic [NCH-1:0][15:0] capture_compare_reg,
    input wire logic [15:0]          count_value,
    input wire logic                 wrap_flag,
    input wire logic                 wrap_irq,
    input wire logic [NCH-1:0]       channel_event_irq,
    input wire logic [NCH-1:0]       timer_out_pin
);
    // ----------------------------------------------------------------
    // free and pwm mode properties
    // ----------------------------------------------------------------
    wire run_f = count_run_bit && operating_mode_field == QCT_MODE_FREE;
    wire top_f = run_f && count_value == QCT_CNT_MAX;
    wire pwm_m = operating_mode_field == QCT_MODE_PWM;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_wrap_on_max: assert property (top_f |=> count_value == QCT_CNT_ZERO && wrap_irq)
        else $error("wrap missing");
    a_flag_set: assert property (wrap_irq |-> wrap_flag)
        else $error("flag not set");
    a_flag_clear: assert property (bit_clear_instruction && !top_f |=> !wrap_flag)
        else $error("flag not cleared");
    a_count_step: assert property (run_f && !top_f |=> count_value == $past(count_value) + 16'h0001)
        else $error("count not advancing");
    a_stop_zero: assert property (!count_run_bit |=> count_value == QCT_CNT_ZERO)
        else $error("count moved while stopped");
    a_stop_quiet: assert property (!count_run_bit [*2] |-> !wrap_irq && channel_event_irq == '0)
        else $error("event while stopped");
    a_run_toggle: assert property (run_f && $rose(count_run_bit) |=> timer_out_pin == ~$past(timer_out_pin))
        else $error("start toggle missing");
    a_match_hit: assert property (run_f && !channel_function_sel[0] && count_value == capture_compare_reg[0]
        |-> channel_event_irq[0] ##1 timer_out_pin[0] != $past(timer_out_pin[0]))
        else $error("compare match missed");
    a_pwm_zero: assert property ((pwm_m && capture_compare_reg[1] == 16'h0000) [*2] |-> !timer_out_pin[1])
        else $error("zero duty not inactive");
    a_pwm_match: assert property (pwm_m && count_run_bit && count_value == capture_compare_reg[1]
        |-> channel_event_irq[1])
        else $error("pwm match missed");
    a_capture_val: assert property (run_f && channel_function_sel[2] && channel_event_irq[2]
        |-> capture_compare_reg[2] == $past(count_value))
        else $error("capture value wrong");
endmodule
bind qct_timer qct_timer_properties #(.NCH(NCH)) u_props (.*);
`default_nettype wire

/* File: qct_timer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module qct_timer_tb
    import qct_pkg::*;
;
    logic            clk = 1'b0;
    logic            reset = 1'b1;
    logic [2:0]      operating_mode_field = QCT_MODE_FREE;
    logic            count_run_bit = 1'b0;
    logic [3:0]      channel_function_sel = 4'h0;
    logic [7:0]      capture_edge_sel = 8'h00;
    logic            ccr_wr_en = 1'b0;
    logic [1:0]      ccr_wr_idx = 2'h0;
    logic [15:0]     ccr_wr_data = 16'h0000;
    logic            opt_byte_wr = 1'b0;
    logic [7:0]      opt_byte_data = 8'hFF;
    logic            bit_clear_instruction = 1'b0;
    logic [3:0]      capture_in_pin = 4'h0;
    logic [3:0][15:0] capture_compare_reg;
    logic [15:0]     count_value;
    logic            wrap_flag;
    logic            wrap_irq;
    logic [3:0]      channel_event_irq;
    logic [3:0]      timer_out_pin;
    int              error_cnt = 0;
    int              tests_run = 0;

    qct_timer u_qct_timer (.*);

    initial forever #12.5 clk = ~clk;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [1:0] idx, input logic [15:0] d);
        ccr_wr_en = 1'b1;
        ccr_wr_idx = idx;
        ccr_wr_data = d;
        cyc(1);
        ccr_wr_en = 1'b0;
        cyc(1);
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_compare();
        wr(2'h0, 16'h0002);
        wr(2'h1, 16'h0006);
        wr(2'h2, 16'h0009);
        wr(2'h3, 16'h0009);
        count_run_bit = 1'b1;
        cyc(1);
        chk("count", 16'h0001, count_value);
        chk("pins", 16'h000F, 16'(timer_out_pin));
        cyc(1);
        chk("irq", 16'h0001, 16'(channel_event_irq));
        cyc(1);
        chk("pins", 16'h000E, 16'(timer_out_pin));
        wr(2'h1, 16'h0005);
        chk("irq", 16'h0002, 16'(channel_event_irq));
        wr(2'h0, 16'(16'h0002 + 16'h0006));
        cyc(1);
        chk("irq0", 16'h0001, 16'(channel_event_irq[0]));
        count_run_bit = 1'b0;
        cyc(2);
        chk("count", 16'h0000, count_value);
        $display("compare test done");
    endtask
    task automatic t_wrap();
        count_run_bit = 1'b1;
        for (int i = 0; i < 70000 && count_value !== QCT_CNT_MAX; i++)
            cyc(1);
        bit_clear_instruction = 1'b1;
        cyc(1);
        bit_clear_instruction = 1'b0;
        chk("count", QCT_CNT_ZERO, count_value);
        chk("wrap irq", 16'h0001, 16'(wrap_irq));
        chk("flag", 16'h0001, 16'(wrap_flag));
        opt_byte_wr = 1'b1;
        cyc(1);
        opt_byte_wr = 1'b0;
        chk("flag", 16'h0001, 16'(wrap_flag));
        opt_byte_data = 8'hFE;
        opt_byte_wr = 1'b1;
        cyc(1);
        opt_byte_wr = 1'b0;
        opt_byte_data = 8'hFF;
        chk("flag", 16'h0000, 16'(wrap_flag));
        count_run_bit = 1'b0;
        cyc(1);
        $display("wrap test done");
    endtask
    task automatic t_capture();
        int i;
        logic [15:0] first_cap;
        channel_function_sel = 4'h4;
        capture_edge_sel = 8'h10;
        count_run_bit = 1'b1;
        cyc(4);
        capture_in_pin = 4'h4;
        for (i = 0; i < 8 && channel_event_irq[2] !== 1'b1; i++)
            cyc(1);
        chk("cap irq", 16'h0001, 16'(channel_event_irq[2]));
        chk("captured", 16'(3 + i), capture_compare_reg[2]);
        chk("count", 16'(4 + i), count_value);
        capture_in_pin = 4'h0;
        cyc(1);
        chk("cap irq", 16'h0000, 16'(channel_event_irq[2]));
        first_cap = capture_compare_reg[2];
        cyc(3);
        capture_in_pin = 4'h4;
        cyc(4);
        chk("cap irq", 16'h0001, 16'(channel_event_irq[2]));
        chk("pulse", 16'h0008, 16'(capture_compare_reg[2] - first_cap));
        capture_in_pin = 4'h0;
        count_run_bit = 1'b0;
        cyc(1);
        $display("capture test done");
    endtask
    task automatic t_pwm();
        operating_mode_field = QCT_MODE_PWM;
        wr(2'h0, 16'h0003);
        wr(2'h1, 16'h0000);
        wr(2'h2, 16'h0004);
        count_run_bit = 1'b1;
        cyc(2);
        repeat (8)
        begin
            chk("pin1", 16'h0000, 16'(timer_out_pin[1]));
            chk("pin2", 16'h0001, 16'(timer_out_pin[2]));
            cyc(1);
        end
        count_run_bit = 1'b0;
        $display("pwm test done");
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        #1;
        reset = 1'b0;
        chk("reset count", 16'h0000, count_value);
        t_compare();
        t_wrap();
        t_capture();
        t_pwm();
        report_and_stop();
    end
    initial
    begin
        repeat (80000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
endmodule
`default_nettype wire
